// >>> fbae_pkg.sv
// shared constants, types and address decode for the flash bank access link
package fbae_pkg;
  // clock and nominal operation times
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned PROG_TIME_US = 40;
  localparam int unsigned SECT_ERASE_MS = 30;
  localparam int unsigned PROGRAM_BANK_FIRST_ERASE_MS = 300;
  localparam int unsigned PROGRAM_BANK_SECOND_ERASE_MS = 240;
  localparam int unsigned EE_ERASE_MS = 80;
  localparam int unsigned PROG_CYC = PROG_TIME_US * CLK_MHZ;
  localparam int unsigned SECT_CYC = SECT_ERASE_MS * 1000 * CLK_MHZ;
  localparam int unsigned PROGRAM_BANK_FIRST_CYC = PROGRAM_BANK_FIRST_ERASE_MS * 1000 * CLK_MHZ;
  localparam int unsigned PROGRAM_BANK_SECOND_CYC = PROGRAM_BANK_SECOND_ERASE_MS * 1000 * CLK_MHZ;
  localparam int unsigned EE_CYC = EE_ERASE_MS * 1000 * CLK_MHZ;
  // bank address map
  localparam logic [31:0] B0_TOP = 32'h0017_ffff;
  localparam logic [31:0] B1_BASE = 32'h0018_0000;
  localparam logic [31:0] B1_TOP = 32'h002f_ffff;
  localparam logic [31:0] EE_BASE = 32'hf020_0000;
  localparam logic [31:0] EE_TOP = 32'hf020_ffff;
  localparam logic [31:0] SMALL_AREA = 32'h0002_0000;
  localparam int unsigned SMALL_SH = 15;
  localparam int unsigned BIG_SH = 17;
  localparam int unsigned EE_SH = 14;
  localparam int unsigned SMALL_CNT = 4;
  localparam int unsigned WORD_SH = 4;
  // array word: two halves of 64 data bits plus 8 check bits
  localparam int unsigned WORD_W = 144;
  localparam int unsigned HALF_W = 72;
  localparam int unsigned DATA_W = 64;
  localparam int unsigned ECC_W = 8;
  typedef enum logic [1:0] {OP_PROG = 2'h0, OP_SECT = 2'h1, OP_BANK = 2'h2} fbae_op_t;
  localparam logic [1:0] BK_P0 = 2'h0;
  localparam logic [1:0] BK_P1 = 2'h1;
  localparam logic [1:0] BK_EE = 2'h2;
  localparam logic [1:0] BK_NONE = 2'h3;
  // endurance limits in erase cycles
  localparam int unsigned WEAR_PROG_MAX = 1000;
  localparam int unsigned WEAR_EE_MAX = 100000;
  // host register map
  localparam logic [7:0] R_CTRL = 8'h00;
  localparam logic [7:0] R_FADDR = 8'h04;
  localparam logic [7:0] R_FCMD = 8'h08;
  localparam logic [7:0] R_FLO = 8'h0c;
  localparam logic [7:0] R_FHI = 8'h10;
  localparam logic [7:0] R_STAT = 8'h14;
  localparam logic [7:0] R_OADDR = 8'h18;
  localparam logic [7:0] R_OCMD = 8'h1c;
  localparam logic [7:0] R_ODAT0 = 8'h20;
  localparam logic [7:0] R_ODAT3 = 8'h2c;
  localparam logic [7:0] R_WEAR0 = 8'h30;
  localparam logic [7:0] R_WEAR2 = 8'h38;
  localparam logic [31:0] CTRL_MASK = 32'h0e00_0003;
  localparam int unsigned CTRL_PIPE = 0;
  localparam int unsigned CTRL_EVT = 1;
  localparam int unsigned CTRL_PCHK = 25;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // which bank an address falls in
  function automatic logic [1:0] bankOf(input logic [31:0] a);
    if (a <= B0_TOP) bankOf = BK_P0;
    else if (a >= B1_BASE && a <= B1_TOP) bankOf = BK_P1;
    else if (a >= EE_BASE && a <= EE_TOP) bankOf = BK_EE;
    else bankOf = BK_NONE;
  endfunction

  // byte offset inside the bank
  function automatic logic [31:0] offOf(input logic [1:0] bk, input logic [31:0] a);
    if (bk == BK_P1) offOf = a - B1_BASE;
    else if (bk == BK_EE) offOf = a - EE_BASE;
    else offOf = a;
  endfunction

  // sector number of a bank offset
  function automatic logic [3:0] secOf(input logic [1:0] bk, input logic [31:0] off);
    secOf = 4'h0;
    if (bk == BK_P0) begin
      if (off < SMALL_AREA) secOf = 4'(off >> SMALL_SH);
      else secOf = 4'((off >> BIG_SH) + 32'(SMALL_CNT - 1));
    end else if (bk == BK_P1) begin
      secOf = 4'(off >> BIG_SH);
    end else if (bk == BK_EE) begin
      secOf = 4'(off >> EE_SH);
    end
  endfunction
endpackage

// >>> fbae_if.sv
// link between the flash module and the processor fetch and command port
`timescale 1ns/1ps
`default_nettype none
interface fbae_if;
  import fbae_pkg::*;
  logic fetchReq;
  logic fetchInstr;
  logic [31:0] fetchAddr;
  logic fetchReady;
  logic fetchValid;
  logic fetchAbort;
  logic [DATA_W-1:0] fetchData;
  logic [ECC_W-1:0] fetchEcc;
  logic eccEvent;
  logic pipeMode;
  logic opReq;
  logic [1:0] opKind;
  logic [31:0] opAddr;
  logic [WORD_W-1:0] opWord;
  logic opAccept;
  logic opRefused;
  logic opDone;
  logic [2:0] busy;
  modport dev (
    input fetchReq, fetchInstr, fetchAddr, eccEvent, pipeMode, opReq, opKind, opAddr, opWord,
    output fetchReady, fetchValid, fetchAbort, fetchData, fetchEcc, opAccept, opRefused,
    output opDone, busy
  );
  modport host (
    output fetchReq, fetchInstr, fetchAddr, eccEvent, pipeMode, opReq, opKind, opAddr, opWord,
    input fetchReady, fetchValid, fetchAbort, fetchData, fetchEcc, opAccept, opRefused,
    input opDone, busy
  );
endinterface
`default_nettype wire

// >>> fbae_flash_dev.sv
// flash module end: bank decode, word store, fetch path and program/erase engine
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - first program bank: 1.5 MB, fifteen sectors
// - second program bank: twelve 128 KB sectors
// - emulation bank: four 16 KB sectors
// - one to sixteen sectors share bank logic
// - erase always covers a whole sector
// - array word is 144 bits with check bits
// - emulation bank programs while code fetches continue
// - no instruction fetch from emulation bank
// - read one bank while another is busy
// - engine runs program and erase by itself
// - pipelined read mode for more bandwidth
// - return stored 8-bit code per 64 bits
// - processor checks code, corrects single, flags multi
// - error events only after export enable set
// - software sets three port check enables; only CTRL_PCHK, the program port enable, gates any checking
// - capture failing fetch address for debug
// - word program takes 40 us nominal
// - limit erase cycles to 1000 and 100000
module fbae_flash_dev #(
  parameter int unsigned WORDS = 64, // modelled words per bank, from its base
  parameter int unsigned PROG_CYCLES = fbae_pkg::PROG_CYC, // word program time
  parameter int unsigned SECT_CYCLES = fbae_pkg::SECT_CYC, // sector erase time
  parameter int unsigned PROGRAM_BANK_FIRST_CYCLES = fbae_pkg::PROGRAM_BANK_FIRST_CYC, // first bank erase
  parameter int unsigned PROGRAM_BANK_SECOND_CYCLES = fbae_pkg::PROGRAM_BANK_SECOND_CYC, // second bank erase
  parameter int unsigned EE_CYCLES = fbae_pkg::EE_CYC // emulation bank erase
) (
  input wire logic clk, // 250 MHz system clock
  input wire logic resetn, // synchronous reset, active low
  fbae_if.dev lnk, // processor side
  input wire logic errClr, // clears the captured error
  output logic [2:0] bankBusy, // engine busy per bank
  output logic [31:0] errAddr, // address of the last failing fetch
  output logic errValid // errAddr holds a capture
);
  import fbae_pkg::*;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} fbae_st_t;
  localparam logic [31:0] MODEL_BYTES = 32'(WORDS) << WORD_SH;

  // word store; a word never programmed or since erased reads all ones
  logic [WORD_W-1:0] mem [3*WORDS];
  logic [3*WORDS-1:0] val_r, val_nxt;

  logic rdV1_r, rdV1_nxt, rdI1_r, rdI1_nxt, ready_r, ready_nxt;
  logic [31:0] rdA1_r, rdA1_nxt, ansA_r, ansA_nxt, prevA_r, errA_r, errA_nxt;
  logic fValid_r, fValid_nxt, fAbort_r, fAbort_nxt, errV_r, errV_nxt;
  logic [DATA_W-1:0] fData_r, fData_nxt;
  logic [ECC_W-1:0] fEcc_r, fEcc_nxt;
  logic take, ans, selI, rBad;
  logic [31:0] selA, rOff, rIdx;
  logic [1:0] rBk;
  logic [2:0] busy_r, busy_nxt;
  logic [WORD_W-1:0] rWord;
  logic [HALF_W-1:0] rHalf;

  // fetch path: non-pipelined holds one wait stage, pipelined answers next cycle
  always_comb begin
    take = lnk.fetchReq & ready_r;
    // pipe mode skips the wait stage
    rdV1_nxt = take & ~lnk.pipeMode;
    rdA1_nxt = rdV1_nxt ? lnk.fetchAddr : rdA1_r;
    rdI1_nxt = rdV1_nxt ? lnk.fetchInstr : rdI1_r;
    ans = rdV1_r | (take & lnk.pipeMode);
    ready_nxt = ~rdV1_nxt;
    selA = rdV1_r ? rdA1_r : lnk.fetchAddr;
    selI = rdV1_r ? rdI1_r : lnk.fetchInstr;
    rBk = bankOf(selA);
    rOff = offOf(rBk, selA);
    rIdx = 32'(rBk) * 32'(WORDS) + (rOff >> WORD_SH);
    rWord = '1;
    if (rBk != BK_NONE && rOff < MODEL_BYTES) begin
      if (val_r[rIdx]) rWord = mem[rIdx];
    end
    // pick the 72-bit half holding this doubleword
    rHalf = selA[3] ? rWord[WORD_W-1:HALF_W] : rWord[HALF_W-1:0];
    // unmapped addresses abort; of the banks, the one under program or erase aborts, and the emulation bank on an instruction fetch
    rBad = 1'b1;
    if (rBk != BK_NONE) begin
      // instruction fetch from the emulation bank aborts
      rBad = busy_r[rBk] | (selI & (rBk == BK_EE));
    end
    fValid_nxt = ans & ~rBad;
    fAbort_nxt = ans & rBad;
    // stored check byte goes out beside its data
    fData_nxt = ans ? rHalf[DATA_W-1:0] : fData_r;
    fEcc_nxt = ans ? rHalf[HALF_W-1:DATA_W] : fEcc_r;
    ansA_nxt = ans ? selA : ansA_r;
    // event arrives one cycle after the answer, so use the delayed address
    errA_nxt = lnk.eccEvent ? prevA_r : errA_r;
    errV_nxt = lnk.eccEvent | (errV_r & ~errClr);
  end

  // fetch path registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdV1_r <= 1'b0;
      rdI1_r <= 1'b0;
      rdA1_r <= 32'h0000_0000;
      ready_r <= 1'b1;
      fValid_r <= 1'b0;
      fAbort_r <= 1'b0;
      fData_r <= '0;
      fEcc_r <= '0;
      ansA_r <= 32'h0000_0000;
      prevA_r <= 32'h0000_0000;
      errA_r <= 32'h0000_0000;
      errV_r <= 1'b0;
    end else begin
      rdV1_r <= rdV1_nxt;
      rdI1_r <= rdI1_nxt;
      rdA1_r <= rdA1_nxt;
      ready_r <= ready_nxt;
      fValid_r <= fValid_nxt;
      fAbort_r <= fAbort_nxt;
      fData_r <= fData_nxt;
      fEcc_r <= fEcc_nxt;
      ansA_r <= ansA_nxt;
      prevA_r <= ansA_r;
      errA_r <= errA_nxt;
      errV_r <= errV_nxt;
    end
  end

  fbae_st_t st_r, st_nxt;
  logic [31:0] cnt_r, cnt_nxt, oOff, wIdx;
  logic acc_r, acc_nxt, ref_r, ref_nxt, done_r, done_nxt, memWe;
  logic [1:0] oBk;
  logic [3:0] oSec;
  logic [WORD_W-1:0] memWd;

  // program/erase engine; one operation at a time, later requests are refused
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    val_nxt = val_r;
    acc_nxt = 1'b0;
    ref_nxt = 1'b0;
    done_nxt = 1'b0;
    memWe = 1'b0;
    memWd = '1;
    oBk = bankOf(lnk.opAddr);
    oOff = offOf(oBk, lnk.opAddr);
    oSec = secOf(oBk, oOff);
    wIdx = 32'(oBk) * 32'(WORDS) + (oOff >> WORD_SH);
    case (st_r)
      ST_IDLE: begin
        if (lnk.opReq && (oBk == BK_NONE || lnk.opKind == 2'h3)) begin
          ref_nxt = 1'b1;
        end else if (lnk.opReq) begin
          // engine takes over the whole sequence
          acc_nxt = 1'b1;
          st_nxt = ST_RUN;
          busy_nxt[oBk] = 1'b1;
          if (lnk.opKind == OP_PROG) begin
            cnt_nxt = 32'(PROG_CYCLES - 1);
            // programming touches only the addressed bank
            if (oOff < MODEL_BYTES) begin
              memWe = 1'b1;
              memWd = (val_r[wIdx] ? mem[wIdx] : '1) & lnk.opWord;
              val_nxt[wIdx] = 1'b1;
            end
          end else if (lnk.opKind == OP_SECT) begin
            cnt_nxt = 32'(SECT_CYCLES - 1);
            // every word of the sector in one step
            for (int i = 0; i < int'(WORDS); i++) begin
              if (secOf(oBk, 32'(i) << WORD_SH) == oSec) val_nxt[int'(oBk) * WORDS + i] = 1'b0;
            end
          end else begin
            if (oBk == BK_P0) cnt_nxt = 32'(PROGRAM_BANK_FIRST_CYCLES - 1);
            else if (oBk == BK_P1) cnt_nxt = 32'(PROGRAM_BANK_SECOND_CYCLES - 1);
            else cnt_nxt = 32'(EE_CYCLES - 1);
            for (int i = 0; i < int'(WORDS); i++) begin
              val_nxt[int'(oBk) * WORDS + i] = 1'b0;
            end
          end
        end
      end
      ST_RUN: begin
        ref_nxt = lnk.opReq;
        if (cnt_r == 32'h0000_0000) begin
          // busy clears as the operation completes
          busy_nxt = 3'h0;
          done_nxt = 1'b1;
          st_nxt = ST_IDLE;
        end else begin
          cnt_nxt = cnt_r - 32'h0000_0001;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
        busy_nxt = 3'h0;
      end
    endcase
  end

  // engine registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_r <= ST_IDLE;
      cnt_r <= 32'h0000_0000;
      busy_r <= 3'h0;
      val_r <= '0;
      acc_r <= 1'b0;
      ref_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
      val_r <= val_nxt;
      acc_r <= acc_nxt;
      ref_r <= ref_nxt;
      done_r <= done_nxt;
    end
  end

  // array contents need no reset; the valid bits hide stale words
  always_ff @(posedge clk) begin
    if (memWe) mem[wIdx] <= memWd;
  end

  // outputs straight from flops
  assign lnk.fetchReady = ready_r;
  assign lnk.fetchValid = fValid_r;
  assign lnk.fetchAbort = fAbort_r;
  assign lnk.fetchData = fData_r;
  assign lnk.fetchEcc = fEcc_r;
  assign lnk.opAccept = acc_r;
  assign lnk.opRefused = ref_r;
  assign lnk.opDone = done_r;
  assign lnk.busy = busy_r;
  assign bankBusy = busy_r;
  assign errAddr = errA_r;
  assign errValid = errV_r;
endmodule
`default_nettype wire

// >>> fbae_flash_host.sv
// processor end: fetch with check-byte test, program/erase commands, wear count
`timescale 1ns/1ps
`default_nettype none
module fbae_flash_host (
  input wire logic clk, // 250 MHz system clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic [7:0] regAddr, // register byte address
  input wire logic [31:0] regWdata, // write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  output logic [31:0] regRdata, // read data, cycle after regRd
  fbae_if.host lnk // flash module side
);
  import fbae_pkg::*;

  // check-column code of data bit i: the i-th 7-bit value of weight two or more
  function automatic logic [6:0] colOf(input int i);
    int n;
    n = 0;
    colOf = 7'h00;
    for (int k = 3; k < 128; k++) begin
      if ((k & (k - 1)) != 0) begin
        if (n == i) colOf = 7'(k);
        n++;
      end
    end
  endfunction

  // 7 check bits plus overall parity
  function automatic logic [ECC_W-1:0] eccOf(input logic [DATA_W-1:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 0; i < int'(DATA_W); i++) begin
      if (d[i]) c = c ^ colOf(i);
    end
    eccOf = {(^d) ^ (^c), c};
  endfunction

  logic [31:0] ctrl_r, ctrl_nxt, fAddr_r, fAddr_nxt, oAddr_r, oAddr_nxt, rdata_r, rdata_nxt;
  logic fReq_r, fReq_nxt, fIns_r, fIns_nxt, fPend_r, fPend_nxt, evt_r, evt_nxt;
  logic sgl_r, sgl_nxt, mul_r, mul_nxt, abt_r, abt_nxt, ref_r, ref_nxt, wear_r, wear_nxt;
  logic oReq_r, oReq_nxt, oPend_r, oPend_nxt;
  logic [1:0] oKind_r, oKind_nxt, oBk;
  logic [DATA_W-1:0] fData_r, fData_nxt, fixed;
  logic [127:0] oData_r, oData_nxt;
  logic [WORD_W-1:0] oWord_r, oWord_nxt;
  logic [16:0] wCnt_r [3];
  logic [16:0] wCnt_nxt [3];
  logic [6:0] syn;
  logic par, chk, isSgl, isMul, wrC;
  logic [1:0] wKind;

  always_comb begin
    ctrl_nxt = ctrl_r;
    fAddr_nxt = fAddr_r;
    oAddr_nxt = oAddr_r;
    fReq_nxt = fReq_r & ~lnk.fetchReady;
    fIns_nxt = fIns_r;
    fPend_nxt = fPend_r;
    fData_nxt = fData_r;
    oReq_nxt = 1'b0;
    oPend_nxt = oPend_r;
    oKind_nxt = oKind_r;
    oData_nxt = oData_r;
    oWord_nxt = oWord_r;
    wCnt_nxt = wCnt_r;
    rdata_nxt = 32'h0000_0000;
    wrC = regWr && regAddr == R_STAT;
    wKind = regWdata[1:0];
    oBk = bankOf(oAddr_r);
    // recompute, compare, correct a single and flag a multiple
    syn = 7'(eccOf(lnk.fetchData) ^ lnk.fetchEcc);
    par = ^{lnk.fetchData, lnk.fetchEcc};
    // checking only with the program port check enabled
    chk = ctrl_r[CTRL_PCHK] & lnk.fetchValid;
    isSgl = chk & par;
    isMul = chk & ~par & (syn != 7'h00);
    fixed = lnk.fetchData;
    for (int i = 0; i < int'(DATA_W); i++) begin
      if (isSgl && colOf(i) == syn) fixed[i] = ~fixed[i];
    end
    // events reach the flash module only when export is enabled
    evt_nxt = (isSgl | isMul) & ctrl_r[CTRL_EVT];
    // sticky flags: a new event wins over a write-one clear
    sgl_nxt = isSgl | (sgl_r & ~(wrC & regWdata[1]));
    mul_nxt = isMul | (mul_r & ~(wrC & regWdata[2]));
    abt_nxt = lnk.fetchAbort | (abt_r & ~(wrC & regWdata[3]));
    ref_nxt = lnk.opRefused | (ref_r & ~(wrC & regWdata[4]));
    wear_nxt = wear_r & ~(wrC & regWdata[5]);
    if (lnk.fetchValid || lnk.fetchAbort) begin
      fPend_nxt = 1'b0;
      fData_nxt = fixed;
    end
    if (lnk.opRefused || lnk.opDone) oPend_nxt = 1'b0;
    // count erases per bank once accepted
    if (lnk.opAccept && oKind_r != OP_PROG && oBk != BK_NONE) begin
      wCnt_nxt[oBk] = wCnt_r[oBk] + 17'h00001;
    end
    // register writes
    if (regWr) begin
      if (regAddr == R_CTRL) begin
        ctrl_nxt = regWdata & CTRL_MASK;
      end else if (regAddr == R_FADDR) begin
        fAddr_nxt = regWdata;
      end else if (regAddr == R_FCMD && !fPend_r) begin
        // no instruction fetch from the emulation bank
        if (regWdata[0] && bankOf(fAddr_r) == BK_EE) begin
          abt_nxt = 1'b1;
        end else begin
          fReq_nxt = 1'b1;
          fIns_nxt = regWdata[0];
          fPend_nxt = 1'b1;
        end
      end else if (regAddr == R_OADDR) begin
        oAddr_nxt = regWdata;
      end else if (regAddr == R_OCMD && !oPend_r) begin
        if (wKind != OP_PROG && oBk != BK_NONE &&
            32'(wCnt_r[oBk]) >= (oBk == BK_EE ? WEAR_EE_MAX : WEAR_PROG_MAX)) begin
          wear_nxt = 1'b1;
        end else begin
          oReq_nxt = 1'b1;
          oPend_nxt = 1'b1;
          oKind_nxt = wKind;
          oWord_nxt = {eccOf(oData_r[127:64]), oData_r[127:64],
                       eccOf(oData_r[63:0]), oData_r[63:0]};
        end
      end else if (regAddr >= R_ODAT0 && regAddr <= R_ODAT3) begin
        oData_nxt[32*regAddr[3:2] +: 32] = regWdata;
      end
    end
    // register reads, answered on the next cycle
    if (regRd) begin
      if (regAddr == R_CTRL) rdata_nxt = ctrl_r;
      else if (regAddr == R_FADDR) rdata_nxt = fAddr_r;
      else if (regAddr == R_FLO) rdata_nxt = fData_r[31:0];
      else if (regAddr == R_FHI) rdata_nxt = fData_r[63:32];
      else if (regAddr == R_STAT) rdata_nxt = {22'h0, lnk.busy, oPend_r, wear_r, ref_r,
                                               abt_r, mul_r, sgl_r, fPend_r};
      else if (regAddr == R_OADDR) rdata_nxt = oAddr_r;
      else if (regAddr >= R_WEAR0 && regAddr <= R_WEAR2) rdata_nxt = 32'(wCnt_r[regAddr[3:2]]);
    end
  end

  // host registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_r <= CTRL_RST;
      fAddr_r <= 32'h0000_0000;
      oAddr_r <= 32'h0000_0000;
      rdata_r <= 32'h0000_0000;
      fReq_r <= 1'b0;
      fIns_r <= 1'b0;
      fPend_r <= 1'b0;
      fData_r <= '0;
      evt_r <= 1'b0;
      {sgl_r, mul_r, abt_r, ref_r, wear_r} <= 5'h00;
      oReq_r <= 1'b0;
      oPend_r <= 1'b0;
      oKind_r <= 2'h0;
      oData_r <= '0;
      oWord_r <= '1;
      wCnt_r <= '{default: 17'h00000};
    end else begin
      ctrl_r <= ctrl_nxt;
      fAddr_r <= fAddr_nxt;
      oAddr_r <= oAddr_nxt;
      rdata_r <= rdata_nxt;
      fReq_r <= fReq_nxt;
      fIns_r <= fIns_nxt;
      fPend_r <= fPend_nxt;
      fData_r <= fData_nxt;
      evt_r <= evt_nxt;
      {sgl_r, mul_r, abt_r, ref_r, wear_r} <= {sgl_nxt, mul_nxt, abt_nxt, ref_nxt, wear_nxt};
      oReq_r <= oReq_nxt;
      oPend_r <= oPend_nxt;
      oKind_r <= oKind_nxt;
      oData_r <= oData_nxt;
      oWord_r <= oWord_nxt;
      wCnt_r <= wCnt_nxt;
    end
  end

  assign regRdata = rdata_r;
  assign lnk.fetchReq = fReq_r;
  assign lnk.fetchInstr = fIns_r;
  assign lnk.fetchAddr = fAddr_r;
  assign lnk.eccEvent = evt_r;
  assign lnk.pipeMode = ctrl_r[CTRL_PIPE];
  assign lnk.opReq = oReq_r;
  assign lnk.opKind = oKind_r;
  assign lnk.opAddr = oAddr_r;
  assign lnk.opWord = oWord_r;
endmodule
`default_nettype wire

// >>> fbae_link_asserts.sv
// checker for the fetch and operation link between the two ends
`timescale 1ns/1ps
`default_nettype none
module fbae_link_asserts
  import fbae_pkg::*;
#(
  parameter int PROG_CYCLES = 8, // word program time
  parameter int SECT_CYCLES = 20 // sector erase time
) (
  input wire logic clk, // system clock
  input wire logic resetn, // sync reset, active low
  input wire logic fetchReq, // fetch request
  input wire logic [31:0] fetchAddr, // fetch address
  input wire logic fetchReady, // device can take
  input wire logic fetchValid, // data answer
  input wire logic fetchAbort, // error answer
  input wire logic pipeMode, // pipelined reads
  input wire logic opReq, // operation request
  input wire logic [1:0] opKind, // operation kind
  input wire logic opAccept, // op taken
  input wire logic opRefused, // op refused
  input wire logic opDone, // op finished
  input wire logic [2:0] busy // engine busy per bank
);
  import fbae_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // a take needs both request and ready
  logic fetchTake;
  assign fetchTake = fetchReq & fetchReady;
  a_pipe_answer: assert property (fetchTake && pipeMode |=> fetchValid || fetchAbort)
    else $error("pipelined fetch not answered next cycle");
  a_slow_answer: assert property (fetchTake && !pipeMode |=> !fetchReady ##1 (fetchValid || fetchAbort))
    else $error("non-pipelined fetch timing wrong");
  a_answer_cause: assert property (fetchValid || fetchAbort |-> $past(fetchTake) || $past(fetchTake, 2))
    else $error("fetch answer without request");
  a_busy_abort: assert property (fetchTake && fetchAddr <= B0_TOP && busy[0] |-> ##[1:2] fetchAbort)
    else $error("read of busy bank not aborted");
  a_gap_abort: assert property (fetchTake && fetchAddr > B1_TOP && fetchAddr < EE_BASE |-> ##[1:2] fetchAbort)
    else $error("unmapped fetch not aborted");
  a_op_answer: assert property (opReq |=> opAccept ^ opRefused)
    else $error("operation not answered next cycle");
  a_busy_accept: assert property (opAccept |-> $onehot(busy))
    else $error("busy not set on accept");
  a_done_idle: assert property (opDone |-> busy == 3'h0 && $past(busy) != 3'h0)
    else $error("busy wrong at done");
  a_prog_time: assert property (opAccept && $past(opKind) == 2'h0 |-> ##PROG_CYCLES opDone)
    else $error("program time wrong");
  a_sect_time: assert property (opAccept && $past(opKind) == 2'h1 |-> ##SECT_CYCLES opDone)
    else $error("sector erase time wrong");
endmodule
`default_nettype wire

// >>> flash_bank_access_ecc_tb_top.sv
// self-checking bench joining the host and flash ends through the link
`timescale 1ns/1ps
`default_nettype none
module flash_bank_access_ecc_tb_top;
  import fbae_pkg::*;
  typedef struct {logic [31:0] a; logic ins; logic pipe; logic ab; logic dat;
    logic [31:0] lo; logic [31:0] hi;} fbae_row_t;
  localparam logic [31:0] DAT [4] = '{32'h1234_5678, 32'h9abc_def0, 32'h0f1e_2d3c, 32'h4b5a_6978};
  logic clk, resetn, regWr, regRd, errClr, errValid;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, s, lo, hi, errAddr;
  logic [2:0] bankBusy;
  int errors, comparisons, cycles;
  fbae_row_t rows [7];
  fbae_if fbae_if_inst ();
  fbae_flash_dev #(.PROG_CYCLES(8), .SECT_CYCLES(20), .PROGRAM_BANK_FIRST_CYCLES(30), .PROGRAM_BANK_SECOND_CYCLES(25),
    .EE_CYCLES(15)) fbae_flash_dev_inst (.clk(clk), .resetn(resetn), .lnk(fbae_if_inst.dev),
    .errClr(errClr), .bankBusy(bankBusy), .errAddr(errAddr), .errValid(errValid));
  fbae_flash_host fbae_flash_host_inst (.clk(clk), .resetn(resetn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .lnk(fbae_if_inst.host));
  fbae_link_asserts fbae_link_asserts_inst (.clk(clk),
    .resetn(resetn), .fetchReq(fbae_if_inst.fetchReq), .fetchAddr(fbae_if_inst.fetchAddr),
    .fetchReady(fbae_if_inst.fetchReady), .fetchValid(fbae_if_inst.fetchValid),
    .fetchAbort(fbae_if_inst.fetchAbort), .pipeMode(fbae_if_inst.pipeMode),
    .opReq(fbae_if_inst.opReq), .opKind(fbae_if_inst.opKind), .opAccept(fbae_if_inst.opAccept),
    .opRefused(fbae_if_inst.opRefused), .opDone(fbae_if_inst.opDone), .busy(fbae_if_inst.busy));
  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // hang guard, generous against the expected few hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end
  task automatic final_report();
    $display("comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  // one-cycle strobes; a gap cycle keeps back-to-back calls clean
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  // poll status until the masked bits clear, bounded
  task automatic wait_clear(input logic [31:0] m);
    for (int i = 0; i < 100; i++) begin
      rd(R_STAT, s);
      if ((s & m) == 32'h0) return;
    end
    chk("status wait", 32'h0, s & m);
  endtask
  task automatic fetch(input logic [31:0] a, input logic ins);
    wr(R_STAT, 32'h3e);
    wr(R_FADDR, a);
    wr(R_FCMD, {31'h0, ins});
    wait_clear(32'h1);
    rd(R_FLO, lo);
    rd(R_FHI, hi);
  endtask
  // main sequence
  initial begin
    {resetn, regWr, regRd, errClr, regAddr, regWdata} = '0;
    {errors, comparisons, cycles} = '0;
    rows = '{'{32'h0018_0010, 1'b0, 1'b1, 1'b0, 1'b1, DAT[0], DAT[1]},
      '{32'h0018_0018, 1'b1, 1'b0, 1'b0, 1'b1, DAT[2], DAT[3]},
      '{32'h0030_0000, 1'b0, 1'b1, 1'b1, 1'b0, 32'h0, 32'h0},
      '{32'hf020_0000, 1'b1, 1'b1, 1'b1, 1'b0, 32'h0, 32'h0},
      '{32'hf020_fff8, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0, 32'h0},
      '{32'h0017_fff8, 1'b1, 1'b1, 1'b0, 1'b0, 32'h0, 32'h0},
      '{32'hf021_0000, 1'b0, 1'b0, 1'b1, 1'b0, 32'h0, 32'h0}};
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    rd(R_STAT, s);
    chk("status after reset", 32'h0, s);
    rd(R_CTRL, s);
    chk("control after reset", CTRL_RST, s);
    wr(R_CTRL, 32'h0e00_0003);
    rd(R_CTRL, s);
    chk("control enables", 32'h0e00_0003, s);
    // program one word of the second bank
    wr(R_OADDR, 32'h0018_0010);
    for (int k = 0; k < 4; k++) wr(R_ODAT0 + 8'(4 * k), DAT[k]);
    wr(R_OCMD, 32'h0);
    wait_clear(32'h40);
    foreach (rows[i]) begin
      wr(R_CTRL, 32'h0e00_0002 | {31'h0, rows[i].pipe});
      fetch(rows[i].a, rows[i].ins);
      chk("fetch abort", {31'h0, rows[i].ab}, {31'h0, s[3]});
      if (rows[i].dat) begin
        chk("fetch low", rows[i].lo, lo);
        chk("fetch high", rows[i].hi, hi);
        chk("check flags", 32'h0, {30'h0, s[2:1]});
      end
    end
    // two programs of one word leave a double error
    for (int k = 1; k < 4; k++) wr(R_ODAT0 + 8'(4 * k), 32'hffff_ffff);
    wr(R_OADDR, 32'h0018_0020);
    for (int k = 0; k < 2; k++) begin
      wr(R_ODAT0, 32'hffff_fffe - 32'(k));
      wr(R_OCMD, 32'h0);
      wait_clear(32'h40);
    end
    fetch(32'h0018_0020, 1'b0);
    chk("double error flags", 32'h4, s & 32'h6);
    chk("uncorrected low", 32'hffff_fffc, lo);
    chk("error address", 32'h0018_0020, errAddr);
    chk("error valid", 32'h1, {31'h0, errValid});
    @(posedge clk);
    errClr <= 1'b1;
    @(posedge clk);
    errClr <= 1'b0;
    #1 chk("error cleared", 32'h0, {31'h0, errValid});
    // read one bank while the other erases as a whole
    wr(R_OADDR, 32'h0000_8000);
    wr(R_OCMD, 32'h2);
    fetch(32'h0000_0000, 1'b0);
    chk("busy bank read", 32'h8, s & 32'h8);
    chk("bank busy", 32'h1, {29'h0, bankBusy});
    fetch(32'h0018_0010, 1'b1);
    chk("other bank read", DAT[0], lo);
    wait_clear(32'h40);
    rd(R_WEAR0, s);
    chk("first bank erase count", 32'h1, s);
    // sector erase of the emulation bank, then a refused kind
    wr(R_OADDR, EE_BASE);
    wr(R_OCMD, 32'h1);
    wait_clear(32'h40);
    rd(R_WEAR2, s);
    chk("emulation erase count", 32'h1, s);
    wr(R_OCMD, 32'h3);
    wait_clear(32'h40);
    chk("refused kind", 32'h10, s & 32'h10);
    final_report();
  end
endmodule
`default_nettype wire
